//--- include/pfs_pkg.sv
// Package for the pin function select and IRQ pin block.
// Assumes a 32-bit APB slave clocked by the peripheral clock.
package pfs_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_PINS = 16;
  localparam int NUM_IRQ = 8;
  localparam int NUM_PERIPH = 32;
  localparam int PSEL_W = 5;
  localparam int IRQ_IDX_W = 3;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] PFS_BASE_OFS = 12'h000;
  localparam logic [11:0] WPROT_OFS = 12'h100;
  localparam logic [11:0] IRQCR_BASE_OFS = 12'h140;
  localparam logic [11:0] PIN_LEVEL_OFS = 12'h180;

  // ------------------------------------------------------------
  // Pin function select fields
  // ------------------------------------------------------------
  localparam int PFS_ODATA_BIT = 0;
  localparam int PFS_LEVEL_BIT = 1;
  localparam int PFS_DIR_BIT = 2;
  localparam int PFS_PULLUP_BIT = 4;
  localparam int PFS_OD_BIT = 6;
  localparam int PFS_DRIVE_LSB = 10;
  localparam int PFS_IRQ_INPUT_SELECT_BIT = 14;
  localparam int PFS_ANALOG_INPUT_SELECT_BIT = 15;
  localparam int PFS_PMODE_BIT = 16;
  localparam int PFS_PSEL_LSB = 24;
  localparam logic [31:0] PFS_WMASK = 32'h1f01_cc55;
  localparam logic [31:0] PFS_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Write protect and IRQ control fields
  // ------------------------------------------------------------
  localparam int WPROT_EN_BIT = 0;
  localparam logic WPROT_RESET = 1'b0;
  localparam int IRQCR_MODE_LSB = 0;
  localparam int IRQCR_FCLK_LSB = 4;
  localparam int IRQCR_IRQ_FILTER_ENABLE_BIT = 7;
  localparam logic [7:0] IRQCR_WMASK = 8'hb3;
  localparam logic [7:0] IRQCR_RESET = 8'h00;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_DET_LOW = 2'h0,
    PFS_DET_FALL = 2'h1,
    PFS_DET_RISE = 2'h2,
    PFS_DET_BOTH = 2'h3
  } pfs_det_t;

  localparam logic [1:0] DRIVE_LOW = 2'h0;
  localparam logic [1:0] DRIVE_MID = 2'h1;
  localparam logic [1:0] DRIVE_MID_FAST = 2'h2;

  // ------------------------------------------------------------
  // Filter clock divider
  // ------------------------------------------------------------
  localparam int DIV_CNT_W = 6;
  localparam logic [5:0] DIV8_LAST = 6'h07;
  localparam logic [5:0] DIV32_LAST = 6'h1f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  localparam int FILTER_SAMPLES = 3;

endpackage : pfs_pkg

//--- rtl/pfs_irq_filter.sv
// Digital noise filter for one IRQ line.
// Assumes a synchronised input and a one-cycle sample tick.
`timescale 1ns/1ps
module pfs_irq_filter (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic i_level,
  output logic o_level
);
  import pfs_pkg::*;

  logic [FILTER_SAMPLES-2:0] hist;
  logic filt;
  wire all_high = i_level & (&hist);
  wire all_low = ~i_level & ~(|hist);

  // ------------------------------------------------------------
  // Sample history and qualified level
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hist <= '0;
      filt <= 1'b0;
    end else if (i_tick) begin
      hist <= {hist[FILTER_SAMPLES-3:0], i_level};
      if (all_high) begin
        filt <= 1'b1;
      end else if (all_low) begin
        filt <= 1'b0;
      end
    end
  end

  assign o_level = i_enable ? filt : i_level;

endmodule : pfs_irq_filter

//--- rtl/pfs_pin_mux.sv
// Pin function select, pad control and IRQ pin detection.
// Assumes APB from software and 2-FF synchronisation of pads.
`timescale 1ns/1ps

// Contract
// - Pull-up bit 1 on, 0 off
// - Pull-up acts only for input pins
// - Pull-up bits reset to zero
// - Pull-up forced off for output functions
// - Open-drain bit 1 NMOS, 0 CMOS
// - Drive field: low, middle, middle fast
// - Drive field resets to low drive
// - Peripheral select routes function to pin
// - Function registers locked until unlocked
// - Duplicate function assignment left undefined
// - IRQ select routes pin to IRQ
// - IRQ and peripheral work together
// - Per IRQ detection mode selection
// - Filter clock divide 1, 8, 32, 64
// - Filter rejects pulses under three samples
// - Per IRQ filter enable bit
// - Filter adds qualification latency
// - Port mode resets to general purpose
// - Direction 1 output, reset input
module pfs_pin_mux (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pfs_pkg::NUM_PINS-1:0] i_pad_in,
  output logic [pfs_pkg::NUM_PINS-1:0] o_pad_out,
  output logic [pfs_pkg::NUM_PINS-1:0] o_pad_oe,
  output logic [pfs_pkg::NUM_PINS-1:0] o_pullup_enable,
  output logic [2*pfs_pkg::NUM_PINS-1:0] o_drive_strength,
  output logic [pfs_pkg::NUM_PINS-1:0] o_analog_enable,
  input wire logic [pfs_pkg::NUM_PERIPH-1:0] i_periph_out,
  input wire logic [pfs_pkg::NUM_PERIPH-1:0] i_periph_oe,
  output logic [pfs_pkg::NUM_PERIPH-1:0] o_periph_in,
  output logic [pfs_pkg::NUM_IRQ-1:0] o_irq_request
);
  import pfs_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] pin_function_select_reg [NUM_PINS];
  logic [7:0] irq_control_reg [NUM_IRQ];
  logic pin_config_write_protect_reg;
  logic [NUM_PINS-1:0] pad_meta;
  logic [NUM_PINS-1:0] pad_level;
  logic [DIV_CNT_W-1:0] div_cnt;
  logic [NUM_IRQ-1:0] irq_prev;
  logic [NUM_IRQ-1:0] irq_req;
  logic [31:0] rdata;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire setup_phase = psel & ~penable;
  wire wr_access = psel & penable & pwrite;
  wire [11:0] pfs_end = PFS_BASE_OFS + 12'(4 * NUM_PINS);
  wire [11:0] irq_end = IRQCR_BASE_OFS + 12'(4 * NUM_IRQ);
  wire hit_pfs = (paddr >= PFS_BASE_OFS) && (paddr < pfs_end) && (paddr[1:0] == 2'h0);
  wire hit_irq = (paddr >= IRQCR_BASE_OFS) && (paddr < irq_end) && (paddr[1:0] == 2'h0);
  wire hit_wprot = paddr == WPROT_OFS;
  wire hit_level = paddr == PIN_LEVEL_OFS;
  wire [11:0] pfs_rel = paddr - PFS_BASE_OFS;
  wire [11:0] irq_rel = paddr - IRQCR_BASE_OFS;
  wire [3:0] pfs_idx = pfs_rel[5:2];
  wire [IRQ_IDX_W-1:0] irq_idx = irq_rel[IRQ_IDX_W+1:2];
  wire [31:0] byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire pfs_unlocked = pin_config_write_protect_reg;
  wire pfs_we = wr_access & hit_pfs & pfs_unlocked;
  wire irq_we = wr_access & hit_irq & pstrb[0];
  wire wprot_we = wr_access & hit_wprot & pstrb[0];
  wire [31:0] pfs_keep = ~(PFS_WMASK & byte_mask);
  wire [31:0] pfs_new = pwdata & PFS_WMASK & byte_mask;

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ------------------------------------------------------------
  // Pad synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pad_meta <= '0;
      pad_level <= '0;
    end else begin
      pad_meta <= i_pad_in;
      pad_level <= pad_meta;
    end
  end

  // ------------------------------------------------------------
  // Write protect register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_config_write_protect_reg <= WPROT_RESET;
    end else if (wprot_we) begin
      pin_config_write_protect_reg <= pwdata[WPROT_EN_BIT];
    end
  end

  // ------------------------------------------------------------
  // Pin function select registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_function_select_reg[p] <= PFS_RESET;
      end
    end else if (pfs_we) begin
      pin_function_select_reg[pfs_idx] <= (pin_function_select_reg[pfs_idx] & pfs_keep) | pfs_new;
    end
  end

  // ------------------------------------------------------------
  // IRQ control registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        irq_control_reg[i] <= IRQCR_RESET;
      end
    end else if (irq_we) begin
      irq_control_reg[irq_idx] <= pwdata[7:0] & IRQCR_WMASK;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_pfs) begin
      rdata = pin_function_select_reg[pfs_idx];
      rdata[PFS_LEVEL_BIT] = pad_level[pfs_idx];
    end else if (hit_irq) begin
      rdata = {24'h00_0000, irq_control_reg[irq_idx]};
    end else if (hit_wprot) begin
      rdata = {31'h0000_0000, pin_config_write_protect_reg};
    end else if (hit_level) begin
      rdata = {{(32 - NUM_PINS){1'b0}}, pad_level};
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      prdata <= rdata;
    end
  end

  // ------------------------------------------------------------
  // Pad control per pin
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] next_pad_out;
  logic [NUM_PINS-1:0] next_pad_oe;
  logic [NUM_PINS-1:0] next_pullup;
  logic [2*NUM_PINS-1:0] next_drive;
  logic [NUM_PINS-1:0] next_analog;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    wire [31:0] cfg = pin_function_select_reg[p];
    wire pmode = cfg[PFS_PMODE_BIT];
    wire [PSEL_W-1:0] fsel = cfg[PFS_PSEL_LSB +: PSEL_W];
    wire per_out = i_periph_out[fsel];
    wire per_oe = i_periph_oe[fsel];
    wire gpio_out = cfg[PFS_DIR_BIT];
    wire drives = pmode ? per_oe : gpio_out;
    wire level = pmode ? per_out : cfg[PFS_ODATA_BIT];
    wire od = cfg[PFS_OD_BIT];
    assign next_pad_out[p] = od ? 1'b0 : level;
    assign next_pad_oe[p] = drives & ~cfg[PFS_ANALOG_INPUT_SELECT_BIT] & (~od | ~level);
    assign next_pullup[p] = cfg[PFS_PULLUP_BIT] & ~drives;
    assign next_drive[2*p +: 2] = cfg[PFS_DRIVE_LSB +: 2];
    assign next_analog[p] = cfg[PFS_ANALOG_INPUT_SELECT_BIT];
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
      o_pullup_enable <= '0;
      o_drive_strength <= '0;
      o_analog_enable <= '0;
    end else begin
      o_pad_out <= next_pad_out;
      o_pad_oe <= next_pad_oe;
      o_pullup_enable <= next_pullup;
      o_drive_strength <= next_drive;
      o_analog_enable <= next_analog;
    end
  end

  // ------------------------------------------------------------
  // Peripheral inputs and raw IRQ lines
  // ------------------------------------------------------------
  logic [NUM_PERIPH-1:0] next_periph_in;
  logic [NUM_IRQ-1:0] irq_raw;
  logic [NUM_IRQ-1:0] irq_routed;

  always_comb begin
    next_periph_in = '0;
    irq_raw = '0;
    irq_routed = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_function_select_reg[p][PFS_PMODE_BIT]) begin
        // Several pins on one function simply OR together
        next_periph_in[pin_function_select_reg[p][PFS_PSEL_LSB +: PSEL_W]] |= pad_level[p];
      end
      if (pin_function_select_reg[p][PFS_IRQ_INPUT_SELECT_BIT]) begin
        irq_raw[p % NUM_IRQ] |= pad_level[p];
        irq_routed[p % NUM_IRQ] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_periph_in <= '0;
    end else begin
      o_periph_in <= next_periph_in;
    end
  end

  // ------------------------------------------------------------
  // Unrouted IRQ lines rest high, so no request
  // ------------------------------------------------------------
  wire [NUM_IRQ-1:0] irq_line = irq_raw | ~irq_routed;

  // ------------------------------------------------------------
  // Filter sample divider
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  wire [3:0] div_tick = {div_cnt == DIV64_LAST, div_cnt[4:0] == DIV32_LAST[4:0],
                         div_cnt[2:0] == DIV8_LAST[2:0], 1'b1};

  // ------------------------------------------------------------
  // IRQ filter and detection
  // ------------------------------------------------------------
  logic [NUM_IRQ-1:0] irq_level;
  logic [NUM_IRQ-1:0] next_irq_req;

  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    wire [1:0] fclk = irq_control_reg[i][IRQCR_FCLK_LSB +: 2];
    pfs_irq_filter u_filter (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_tick(div_tick[fclk]),
      .i_enable(irq_control_reg[i][IRQCR_IRQ_FILTER_ENABLE_BIT]),
      .i_level(irq_line[i]),
      .o_level(irq_level[i])
    );
    wire rise = irq_level[i] & ~irq_prev[i];
    wire fall = ~irq_level[i] & irq_prev[i];
    always_comb begin
      case (pfs_det_t'(irq_control_reg[i][IRQCR_MODE_LSB +: 2]))
        PFS_DET_LOW: next_irq_req[i] = ~irq_level[i];
        PFS_DET_FALL: next_irq_req[i] = fall;
        PFS_DET_RISE: next_irq_req[i] = rise;
        PFS_DET_BOTH: next_irq_req[i] = rise | fall;
        default: next_irq_req[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_prev <= '0;
      irq_req <= '0;
    end else begin
      irq_prev <= irq_level;
      irq_req <= next_irq_req;
    end
  end

  assign o_irq_request = irq_req;

endmodule : pfs_pin_mux

//--- dv/pfs_pin_mux_asserts.sv
// Port checker for the pin function select block.
// Assumes it is bound to every pfs_pin_mux instance.
`timescale 1ns/1ps
module pfs_pin_mux_asserts (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] i_pad_in,
  input wire logic [15:0] o_pad_oe,
  input wire logic [15:0] o_pullup_enable,
  input wire logic [31:0] o_drive_strength,
  input wire logic [31:0] i_periph_out,
  input wire logic [31:0] i_periph_oe,
  input wire logic [31:0] o_periph_in
);
  wire wr = psel && penable && pwrite;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  pull_oe_excl_a: assert property ((o_pullup_enable & o_pad_oe) == 16'h0000)
    else $error("pull-up on a driven pin");
  reset_pull_a: assert property ($fell(i_reset) |-> o_pullup_enable == 16'h0000)
    else $error("pull-up not clear after reset");
  reset_drive_a: assert property ($fell(i_reset) |-> o_drive_strength == 32'h0000_0000)
    else $error("drive not low after reset");
  no_bus_err_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus error or wait seen");
  drive_cause_a: assert property ($changed(o_drive_strength) |-> $past(wr, 2))
    else $error("drive changed without write");
  oe_cause_a: assert property ($changed(o_pad_oe) |-> $past(wr, 2) ||
    $past(i_periph_oe) != $past(i_periph_oe, 2) || $past(i_periph_out) != $past(i_periph_out, 2))
    else $error("output enable changed without cause");
  pull_cause_a: assert property ($changed(o_pullup_enable) |-> $past(wr, 2) || $past(i_periph_oe) != $past(i_periph_oe, 2))
    else $error("pull-up changed without cause");
  periph_lat_a: assert property ($changed(o_periph_in) |-> $past(wr, 2) || $past(i_pad_in, 3) != $past(i_pad_in, 4))
    else $error("peripheral input changed without cause");
endmodule : pfs_pin_mux_asserts

bind pfs_pin_mux pfs_pin_mux_asserts pfs_pin_mux_asserts_inst (.i_clk, .i_reset, .psel, .penable, .pwrite,
  .pready, .pslverr, .i_pad_in, .o_pad_oe, .o_pullup_enable, .o_drive_strength, .i_periph_out, .i_periph_oe,
  .o_periph_in);

//--- dv/pfs_board_model.sv
// Board model that resolves the level on each package pad.
// Assumes chip drive wins over the board source.
`timescale 1ns/1ps
module pfs_board_model (
  input wire logic [15:0] i_pad_out,
  input wire logic [15:0] i_pad_oe,
  input wire logic [15:0] i_pullup_enable,
  input wire logic [15:0] i_ext_val,
  input wire logic [15:0] i_ext_en,
  output logic [15:0] o_pad_level
);
  // Chip drive, then board source, then pull-up, else board pull-down
  assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val)
    | (~i_pad_oe & ~i_ext_en & i_pullup_enable);
endmodule : pfs_board_model

//--- dv/pfs_pin_mux_tb.sv
// Testbench for the pin function select block.
// Assumes the board model on the pads and zero-wait APB.
`timescale 1ns/1ps
module pfs_pin_mux_tb;
  import pfs_pkg::*;
  localparam logic [31:0] PU = 32'h1 << PFS_PULLUP_BIT;
  localparam logic [31:0] DIR = 32'h1 << PFS_DIR_BIT;
  localparam logic [31:0] OD = 32'h1 << PFS_OD_BIT;
  localparam logic [31:0] IS = 32'h1 << PFS_IRQ_INPUT_SELECT_BIT;
  logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, drv, pout, poe, pin;
  logic [15:0] pad_in, pad_out, pad_oe, pu, ana, ext_val, ext_en;
  logic [7:0] irq;
  int errors, total_checks;
  pfs_pin_mux pfs_pin_mux_inst (.i_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_pullup_enable(pu), .o_drive_strength(drv), .o_analog_enable(ana), .i_periph_out(pout),
    .i_periph_oe(poe), .o_periph_in(pin), .o_irq_request(irq));
  pfs_board_model pfs_board_model_inst (.i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pullup_enable(pu),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pad_level(pad_in));
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [11:0] pfs(input int p);
    return PFS_BASE_OFS + 12'(4 * p);
  endfunction : pfs
  function automatic logic [11:0] irc(input int i);
    return IRQCR_BASE_OFS + 12'(4 * i);
  endfunction : irc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic pulse(input int w, input int span, output int n2, output int n3, output int l2, output int l3);
    n2 = 0;
    n3 = 0;
    l2 = -1;
    l3 = -1;
    for (int c = 0; c < span; c++) begin
      @(posedge i_clk);
      ext_val[3:2] <= (c < w) ? 2'b00 : 2'b11;
      #1;
      if (irq[2] === 1'b1 && n2++ == 0) l2 = c;
      if (irq[3] === 1'b1 && n3++ == 0) l3 = c;
    end
  endtask : pulse
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    xfer(0, pfs(5), 0, d);
    chk(d & ~(32'h1 << PFS_LEVEL_BIT), 0);
    xfer(0, WPROT_OFS, 0, d);
    chk(d, 0);
    xfer(0, irc(3), 0, d);
    chk(d, 0);
    chk(drv, 0);
    chk(pu | pad_oe, 0);
    chk(irq, 0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_lock;
    logic [31:0] d;
    xfer(1, pfs(3), 32'h0000_0455, d);
    xfer(0, pfs(3), 0, d);
    chk(d & ~(32'h1 << PFS_LEVEL_BIT), 0);
    xfer(1, WPROT_OFS, 1, d);
    xfer(1, pfs(3), 32'h1, d);
    xfer(0, pfs(3), 0, d);
    chk(d & 32'h1, 1);
    xfer(1, pfs(3), 0, d);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_pad;
    logic [31:0] d;
    xfer(1, pfs(1), PU, d);
    settle(4);
    chk(pu[1], 1);
    xfer(0, pfs(1), 0, d);
    chk(d[PFS_LEVEL_BIT], 1);
    xfer(1, pfs(1), PU | DIR | 32'h1, d);
    settle(2);
    chk({pu[1], pad_oe[1], pad_out[1]}, 3'h3);
    xfer(1, pfs(1), PU | DIR | OD | 32'h1, d);
    settle(2);
    chk({pu[1], pad_oe[1]}, 2'h0);
    xfer(1, pfs(1), PU | DIR | OD, d);
    settle(2);
    chk({pad_oe[1], pad_out[1]}, 2'h2);
    xfer(1, pfs(1), 32'h1 << PFS_ANALOG_INPUT_SELECT_BIT, d);
    settle(2);
    chk({ana[1], pu[1], pad_oe[1]}, 3'h4);
    for (int v = 0; v < 3; v++) begin
      xfer(1, pfs(2), 32'(v) << PFS_DRIVE_LSB, d);
      settle(2);
      chk(drv[5:4], v);
    end
    $display("t_pad done");
  endtask : t_pad
  task automatic t_periph;
    logic [31:0] d;
    xfer(1, pfs(4), (32'h1 << PFS_PMODE_BIT) | IS | (32'h9 << PFS_PSEL_LSB), d);
    poe[9] <= 1;
    pout[9] <= 1;
    settle(2);
    chk({pad_oe[4], pad_out[4]}, 2'h3);
    @(posedge i_clk);
    pout[9] <= 0;
    settle(2);
    chk({pad_oe[4], pad_out[4]}, 2'h2);
    @(posedge i_clk);
    poe[9] <= 0;
    settle(5);
    chk({pin[9], irq[4]}, 2'h2);
    @(posedge i_clk);
    ext_val[4] <= 0;
    settle(5);
    chk({pin[9], irq[4]}, 2'h1);
    @(posedge i_clk);
    ext_val[4] <= 1;
    xfer(1, pfs(4), 0, d);
    $display("t_periph done");
  endtask : t_periph
  task automatic t_modes;
    logic [31:0] d;
    int n2, n3, l2, l3;
    int exp_n[4] = '{10, 1, 1, 2};
    xfer(1, pfs(3), IS, d);
    for (int m = 0; m < 4; m++) begin
      xfer(1, irc(3), 32'(m), d);
      settle(8);
      pulse(10, 30, n2, n3, l2, l3);
      chk(n3, exp_n[m]);
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_filter;
    logic [31:0] d;
    int n2, n3, l2, l3;
    int sh[4] = '{2, 10, 60, 120};
    int lg[4] = '{4, 40, 120, 250};
    xfer(1, pfs(2), IS, d);
    xfer(1, irc(2), 32'(PFS_DET_FALL), d);
    for (int f = 0; f < 4; f++) begin
      xfer(1, irc(3), (32'h1 << IRQCR_IRQ_FILTER_ENABLE_BIT) | 32'(PFS_DET_FALL) | (32'(f) << IRQCR_FCLK_LSB), d);
      settle(200);
      pulse(sh[f], sh[f] + 20, n2, n3, l2, l3);
      chk({n2[3:0], n3[3:0]}, 8'h10);
      settle(200);
      pulse(lg[f], lg[f] + 20, n2, n3, l2, l3);
      chk(n3, 1);
      chk(l3 > l2, 1);
    end
    $display("t_filter done");
  endtask : t_filter
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    #600000;
    errors++;
    tally_and_finish;
  end
  initial begin
    {i_reset, psel, penable, pwrite, paddr, pwdata, pout, poe} = {1'b1, 111'h0};
    ext_val = 16'hffff;
    ext_en = 16'hfffd;
    repeat (3) @(posedge i_clk);
    i_reset <= 0;
    t_reset;
    t_lock;
    t_pad;
    t_periph;
    t_modes;
    t_filter;
    @(posedge i_clk);
    i_reset <= 1;
    repeat (3) @(posedge i_clk);
    i_reset <= 0;
    t_reset;
    tally_and_finish;
  end
endmodule : pfs_pin_mux_tb
